// *** hdl/fsrc_pkg.sv ***
package fsrc_pkg;
	localparam logic [7:0] FSRC_OP_RESUME = 8'hD0;
	localparam logic [7:0] FSRC_OP_SUSPEND = 8'hB0;
	localparam logic [7:0] FSRC_OP_UDPD = 8'h79;
	localparam logic [7:0] FSRC_OP_DPD = 8'hB9;
	localparam logic [7:0] FSRC_OP_DPD_EXIT = 8'hAB;
	localparam logic [7:0] FSRC_OP_RD_CFG = 8'h3F;
	localparam logic [7:0] FSRC_OP_RD_STAT = 8'hD7;
	localparam logic [7:0] FSRC_OP_RD_ID = 8'h9F;
	localparam logic [7:0] FSRC_OP_RST1 = 8'hF0;
	localparam logic [2:0] FSRC_BIT_LAST = 3'h7;
	localparam int FSRC_CLK_MHZ = 10;
	localparam int FSRC_RESUME_TIME_NS = 8000;
	localparam int FSRC_RESUME_CYC_I = (FSRC_RESUME_TIME_NS * FSRC_CLK_MHZ) / 1000;
	localparam logic [7:0] FSRC_RESUME_CYC = FSRC_RESUME_CYC_I[7:0];
	localparam logic [7:0] FSRC_SYNC_CYC = 8'h05;
	typedef enum logic [1:0] {
		FSRC_OP_NONE = 2'b00,
		FSRC_OP_PROG1 = 2'b01,
		FSRC_OP_PROG2 = 2'b10,
		FSRC_OP_ERASE = 2'b11
	} fsrc_op_t;
	typedef struct packed {
		logic buf1_prog_suspended;
		logic buf2_prog_suspended;
		logic erase_suspended;
	} fsrc_susp_t;
	typedef struct packed {
		logic [7:0] opcode;
		logic tog;
	} fsrc_cmd_t;
endpackage : fsrc_pkg

// *** hdl/fsrc_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
// Function
// - Resume continues from the saved progress point.
// - Opcode D0h decodes as resume.
// - No address; trailing bytes ignored until deselect.
// - Restart within resume time after deselect.
// - Clear the matching suspend flag on resume.
// - Busy reported while resumed operation runs.
// - Program resumes first when both suspended.
// - Suspend ignored while resume takes effect.
// - Ultra-deep power-down rejected during suspend.
// - Deep power-down enter and exit rejected.
// - Config, status and ID reads still allowed.
// - Hardware and software reset still accepted.
module fsrc_ctrl (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic suspend_prog1,
	input wire logic suspend_prog2,
	input wire logic suspend_erase,
	input wire logic [15:0] prog_progress,
	input wire logic [15:0] erase_progress,
	input wire logic op_done,
	output logic busy,
	output fsrc_pkg::fsrc_susp_t susp_flags,
	output fsrc_pkg::fsrc_op_t run_op,
	output logic [15:0] restart_point,
	output logic resume_start,
	output logic suspend_ack,
	output logic cmd_allowed,
	output logic cmd_rejected,
	output logic soft_reset
);
	import fsrc_pkg::*;

	// Link side: shift opcode on spi_sck while chip select is low.
	logic [2:0] bit_cnt_r;
	logic [6:0] shreg_r;
	logic first_done_r;
	fsrc_cmd_t link_cmd_r;
	wire logic [7:0] shifted = {shreg_r, spi_mosi};
	always_ff @(posedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			bit_cnt_r <= 3'h0;
			first_done_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == FSRC_BIT_LAST) begin
				first_done_r <= 1'b1;
			end
		end
	end
	always_ff @(posedge spi_sck) begin
		shreg_r <= shifted[6:0];
	end
	// Only the first byte is kept; later bytes never touch the opcode.
	// System reset also clears the toggle so both sides start in step.
	always_ff @(posedge spi_sck or posedge sys_rst) begin
		if (sys_rst) begin
			link_cmd_r.opcode <= 8'h00;
			link_cmd_r.tog <= 1'b0;
		end else if (!spi_cs_n && bit_cnt_r == FSRC_BIT_LAST &&
			!first_done_r) begin
			link_cmd_r.opcode <= shifted;
			link_cmd_r.tog <= ~link_cmd_r.tog;
		end
	end

	// Opcode toggle and chip select cross via three flops.
	logic [2:0] tog_sync_r;
	logic [2:0] cs_sync_r;
	logic tog_seen_r;
	logic [7:0] opcode_r;
	logic have_cmd_r;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tog_sync_r <= 3'h0;
			cs_sync_r <= 3'h7;
		end else begin
			tog_sync_r <= {tog_sync_r[1:0], link_cmd_r.tog};
			cs_sync_r <= {cs_sync_r[1:0], spi_cs_n};
		end
	end
	wire logic tog_stable = tog_sync_r[1] == tog_sync_r[2];
	wire logic new_cmd = tog_stable && (tog_sync_r[2] != tog_seen_r);
	wire logic cs_rise = cs_sync_r[1] && cs_sync_r[2] && have_cmd_r;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tog_seen_r <= 1'b0;
			opcode_r <= 8'h00;
			have_cmd_r <= 1'b0;
		end else if (new_cmd) begin
			tog_seen_r <= tog_sync_r[2];
			opcode_r <= link_cmd_r.opcode;
			have_cmd_r <= 1'b1;
		end else if (cs_rise) begin
			have_cmd_r <= 1'b0;
		end
	end
	wire logic exec = cs_rise;

	// Command classification.
	wire logic is_resume = opcode_r == FSRC_OP_RESUME;
	wire logic is_suspend = opcode_r == FSRC_OP_SUSPEND;
	wire logic is_pwr = (opcode_r == FSRC_OP_UDPD) ||
		(opcode_r == FSRC_OP_DPD) || (opcode_r == FSRC_OP_DPD_EXIT);
	wire logic is_read = (opcode_r == FSRC_OP_RD_CFG) ||
		(opcode_r == FSRC_OP_RD_STAT) || (opcode_r == FSRC_OP_RD_ID);
	wire logic is_rst = opcode_r == FSRC_OP_RST1;

	typedef enum logic [1:0] {
		FSRC_ST_IDLE = 2'b00,
		FSRC_ST_RESUMING = 2'b01,
		FSRC_ST_RUN = 2'b10
	} fsrc_st_t;
	fsrc_st_t st_r;
	fsrc_st_t st_nxt;
	fsrc_susp_t flags_r;
	fsrc_susp_t flags_nxt;
	fsrc_op_t run_r;
	fsrc_op_t run_nxt;
	logic [7:0] res_cnt_r;
	logic [15:0] prog_save_r;
	logic [15:0] erase_save_r;
	logic [15:0] point_r;
	logic start_r;
	logic ack_r;
	logic allow_r;
	logic rej_r;
	logic srst_r;

	wire logic any_susp = flags_r.buf1_prog_suspended ||
		flags_r.buf2_prog_suspended || flags_r.erase_suspended;
	wire logic prog_susp = flags_r.buf1_prog_suspended ||
		flags_r.buf2_prog_suspended;
	wire logic do_resume = exec && is_resume && any_susp &&
		st_r != FSRC_ST_RESUMING;
	wire logic do_suspend = exec && is_suspend && st_r == FSRC_ST_RUN;
	// A suspend by opcode saves the progress point of what was running.
	wire logic save_prog = do_suspend && run_r != FSRC_OP_ERASE;
	wire logic save_erase = do_suspend && run_r == FSRC_OP_ERASE;
	// Program is picked ahead of erase when both are parked.
	wire fsrc_op_t pick = flags_r.buf1_prog_suspended ? FSRC_OP_PROG1 :
		flags_r.buf2_prog_suspended ? FSRC_OP_PROG2 :
		FSRC_OP_ERASE;
	wire logic [15:0] pick_point = (pick == FSRC_OP_ERASE) ?
		erase_save_r : prog_save_r;

	always_comb begin
		st_nxt = st_r;
		flags_nxt = flags_r;
		run_nxt = run_r;
		case (st_r)
		FSRC_ST_IDLE: begin
			if (do_resume) begin
				st_nxt = FSRC_ST_RESUMING;
				run_nxt = pick;
			end
		end
		FSRC_ST_RESUMING: begin
			if (res_cnt_r == 8'h00) begin
				st_nxt = FSRC_ST_RUN;
				case (run_r)
				FSRC_OP_PROG1: flags_nxt.buf1_prog_suspended = 1'b0;
				FSRC_OP_PROG2: flags_nxt.buf2_prog_suspended = 1'b0;
				FSRC_OP_ERASE: flags_nxt.erase_suspended = 1'b0;
				default: flags_nxt = flags_r;
				endcase
			end
		end
		FSRC_ST_RUN: begin
			if (op_done) begin
				st_nxt = FSRC_ST_IDLE;
				run_nxt = FSRC_OP_NONE;
			end else if (do_suspend) begin
				st_nxt = FSRC_ST_IDLE;
				run_nxt = FSRC_OP_NONE;
				case (run_r)
				FSRC_OP_PROG1: flags_nxt.buf1_prog_suspended = 1'b1;
				FSRC_OP_PROG2: flags_nxt.buf2_prog_suspended = 1'b1;
				FSRC_OP_ERASE: flags_nxt.erase_suspended = 1'b1;
				default: flags_nxt = flags_r;
				endcase
			end
		end
		default: st_nxt = FSRC_ST_IDLE;
		endcase
		// External suspend strobes park an operation from outside this block.
		if (suspend_prog1) flags_nxt.buf1_prog_suspended = 1'b1;
		if (suspend_prog2) flags_nxt.buf2_prog_suspended = 1'b1;
		if (suspend_erase) flags_nxt.erase_suspended = 1'b1;
		if (exec && is_rst) begin
			st_nxt = FSRC_ST_IDLE;
			run_nxt = FSRC_OP_NONE;
			flags_nxt = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r <= FSRC_ST_IDLE;
			flags_r <= '0;
			run_r <= FSRC_OP_NONE;
		end else begin
			st_r <= st_nxt;
			flags_r <= flags_nxt;
			run_r <= run_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			res_cnt_r <= 8'h00;
			point_r <= 16'h0000;
			prog_save_r <= 16'h0000;
			erase_save_r <= 16'h0000;
		end else begin
			if (do_resume && st_r == FSRC_ST_IDLE) begin
				// The deselect crossing uses part of the resume time.
				res_cnt_r <= FSRC_RESUME_CYC - FSRC_SYNC_CYC;
				point_r <= pick_point;
			end else if (res_cnt_r != 8'h00) begin
				res_cnt_r <= res_cnt_r - 8'h1;
			end
			if (suspend_prog1 || suspend_prog2 || save_prog) begin
				prog_save_r <= prog_progress;
			end
			if (suspend_erase || save_erase) begin
				erase_save_r <= erase_progress;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			start_r <= 1'b0;
			ack_r <= 1'b0;
			allow_r <= 1'b0;
			rej_r <= 1'b0;
			srst_r <= 1'b0;
		end else begin
			start_r <= st_r == FSRC_ST_RESUMING && res_cnt_r == 8'h00;
			ack_r <= do_suspend;
			allow_r <= exec && any_susp && (is_read || is_rst);
			rej_r <= exec && any_susp && is_pwr;
			srst_r <= exec && is_rst;
		end
	end

	assign busy = st_r != FSRC_ST_IDLE;
	assign susp_flags = flags_r;
	assign run_op = run_r;
	assign restart_point = point_r;
	assign resume_start = start_r;
	assign suspend_ack = ack_r;
	assign cmd_allowed = allow_r;
	assign cmd_rejected = rej_r;
	assign soft_reset = srst_r;

	sequence resume_issued;
		do_resume && st_r == FSRC_ST_IDLE;
	endsequence
	sequence restart_seen;
		##[1:77] resume_start;
	endsequence
	property resume_bound_p;
		@(posedge sys_clk) disable iff (sys_rst) resume_issued |-> restart_seen;
	endproperty
	resume_bound_a: assert property (resume_bound_p)
		else $error("resume did not start in time");
	flag_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(resume_start && run_r == FSRC_OP_ERASE && !$past(suspend_erase)) |->
		!flags_r.erase_suspended)
		else $error("erase flag not cleared");
	busy_run_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		resume_start |-> busy)
		else $error("not busy after resume");
	prog_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(resume_issued and prog_susp) |=> run_r != FSRC_OP_ERASE)
		else $error("erase resumed before program");
	ignore_susp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		st_r == FSRC_ST_RESUMING |=> !suspend_ack)
		else $error("suspend taken during resume");
	pwr_reject_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(exec && any_susp && is_pwr) |=> cmd_rejected)
		else $error("power-down not rejected");
	read_allow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(exec && any_susp && is_read) |=> cmd_allowed && !cmd_rejected)
		else $error("read not allowed in suspend");
	noop_resume_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(exec && is_resume && !any_susp && st_r == FSRC_ST_IDLE) |=>
		st_r == FSRC_ST_IDLE)
		else $error("resume with nothing suspended acted");
	point_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		resume_issued |=> restart_point == $past(pick_point))
		else $error("restart point wrong");
	dpd_reject_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(exec && any_susp && (opcode_r == FSRC_OP_DPD ||
		opcode_r == FSRC_OP_DPD_EXIT)) |=> cmd_rejected && !cmd_allowed)
		else $error("deep power-down not rejected");
	soft_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(exec && is_rst) |=> soft_reset && flags_r == '0)
		else $error("software reset not taken");
endmodule : fsrc_ctrl
`default_nettype wire

// *** sim/fsrc_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module fsrc_host_model (
	output var logic spi_sck,
	output var logic spi_cs_n,
	output var logic spi_mosi
);
	realtime t_rise = 0;
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// Sends an opcode MSB first; a junk byte may trail it.
	task automatic frame(input logic [7:0] op, input logic extra);
		logic [15:0] sh;
		sh = {op, 8'hA5};
		spi_cs_n = 1'b0;
		for (int i = 0; i < (extra ? 16 : 8); i++) begin
			spi_mosi = sh[15 - i];
			#80 spi_sck = 1'b1;
			#80 spi_sck = 1'b0;
		end
		#80 spi_cs_n = 1'b1;
		t_rise = $realtime;
		spi_mosi = ~spi_mosi;
	endtask : frame
endmodule : fsrc_host_model
`default_nettype wire

// *** sim/test_flash_suspend_resume_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_flash_suspend_resume_ctrl;
	import fsrc_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	wire logic spi_sck, spi_cs_n, spi_mosi;
	logic suspend_prog1 = 1'b0, suspend_prog2 = 1'b0;
	logic suspend_erase = 1'b0, op_done = 1'b0;
	logic [15:0] prog_progress = 16'h1234;
	logic [15:0] erase_progress = 16'h0ABC;
	logic busy, resume_start, suspend_ack;
	logic cmd_allowed, cmd_rejected, soft_reset;
	fsrc_susp_t susp_flags;
	fsrc_op_t run_op;
	logic [15:0] restart_point;
	int err_count = 0, samples_checked = 0;
	int n_st = 0, n_ack = 0, n_ok = 0, n_rej = 0, n_srst = 0;
	int a, b;
	realtime t_st, t0;
	logic [7:0] ops [6];
	always #50 sys_clk = ~sys_clk;
	fsrc_host_model host (.spi_sck, .spi_cs_n, .spi_mosi);
	fsrc_ctrl dut (.sys_clk, .sys_rst, .spi_sck, .spi_cs_n, .spi_mosi,
		.suspend_prog1, .suspend_prog2, .suspend_erase, .prog_progress,
		.erase_progress, .op_done, .busy, .susp_flags, .run_op,
		.restart_point, .resume_start, .suspend_ack, .cmd_allowed,
		.cmd_rejected, .soft_reset);
	// Counts one-cycle pulses so that frames can be checked afterwards.
	always @(posedge sys_clk) begin
		n_st += resume_start;
		n_ack += suspend_ack;
		n_ok += cmd_allowed;
		n_rej += cmd_rejected;
		n_srst += soft_reset;
		if (resume_start) t_st = $realtime;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done;
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic pulse(input logic [3:0] m);
		{suspend_prog1, suspend_prog2, suspend_erase, op_done} = m;
		cyc(1);
		{suspend_prog1, suspend_prog2, suspend_erase, op_done} = 4'h0;
		cyc(1);
	endtask : pulse
	task automatic cmd(input logic [7:0] op, input logic extra);
		host.frame(op, extra);
		cyc(8);
	endtask : cmd
	task automatic wait_st(input int n0);
		for (int i = 0; i < 200 && n_st == n0; i++) cyc(1);
		if (n_st == n0) begin
			err_count++;
			test_done;
		end
	endtask : wait_st
	initial begin
		ops = '{FSRC_OP_RD_CFG, FSRC_OP_RD_STAT, FSRC_OP_RD_ID,
			FSRC_OP_UDPD, FSRC_OP_DPD, FSRC_OP_DPD_EXIT};
		cyc(20);
		sys_rst = 1'b0;
		cyc(3);
		chk(susp_flags, 3'h0);
		pulse(4'h2);
		chk(susp_flags, 3'h1);
		for (int i = 0; i < 6; i++) begin
			a = n_ok;
			b = n_rej;
			cmd(ops[i], 1'b0);
			chk(n_ok - a, i < 3);
			chk(n_rej - b, i >= 3);
		end
		pulse(4'h8);
		prog_progress = 16'h5555;
		chk(susp_flags, 3'h5);
		a = n_st;
		b = n_ack;
		cmd(FSRC_OP_RESUME, 1'b1);
		t0 = host.t_rise;
		chk(busy, 1'b1);
		chk(run_op, FSRC_OP_PROG1);
		cmd(FSRC_OP_SUSPEND, 1'b0);
		chk(n_ack - b, 0);
		wait_st(a);
		chk(t_st - t0 > FSRC_RESUME_TIME_NS - 500 &&
			t_st - t0 <= FSRC_RESUME_TIME_NS + 100, 1'b1);
		chk(susp_flags, 3'h1);
		chk(restart_point, 16'h1234);
		chk(busy, 1'b1);
		cmd(FSRC_OP_SUSPEND, 1'b0);
		chk(n_ack - b, 1);
		chk(susp_flags, 3'h5);
		a = n_st;
		cmd(FSRC_OP_RESUME, 1'b0);
		wait_st(a);
		chk(run_op, FSRC_OP_PROG1);
		chk(restart_point, 16'h5555);
		pulse(4'h1);
		chk(busy, 1'b0);
		a = n_st;
		cmd(FSRC_OP_RESUME, 1'b0);
		wait_st(a);
		chk(run_op, FSRC_OP_ERASE);
		chk(restart_point, 16'h0ABC);
		chk(susp_flags, 3'h0);
		pulse(4'h1);
		a = n_st;
		cmd(FSRC_OP_RESUME, 1'b0);
		chk(busy, 1'b0);
		cyc(90);
		chk(n_st - a, 0);
		prog_progress = 16'h6666;
		pulse(4'h4);
		a = n_st;
		cmd(FSRC_OP_RESUME, 1'b0);
		wait_st(a);
		chk(run_op, FSRC_OP_PROG2);
		chk(restart_point, 16'h6666);
		chk(susp_flags, 3'h0);
		pulse(4'h1);
		chk(busy, 1'b0);
		pulse(4'h4);
		a = n_ok;
		b = n_srst;
		cmd(FSRC_OP_RST1, 1'b0);
		chk(n_srst - b, 1);
		chk(n_ok - a, 1);
		chk(susp_flags, 3'h0);
		pulse(4'h2);
		sys_rst = 1'b1;
		cyc(2);
		sys_rst = 1'b0;
		cyc(3);
		chk(susp_flags, 3'h0);
		test_done;
	end
endmodule : test_flash_suspend_resume_ctrl
`default_nettype wire
